/* hdl/mcm_csr_decoder.sv */
// top-level decoder of the mac configuration and status register space
// assumes: host holds read or write and address until waitrequest drops;
// outside groups answer their read strobe with data one cycle later
//
// Functional notes
// - port windows sit back to back from 0x00, each 0x100 above the last.
// - shared registers are stored only once, behind the first port window.
// - writing a shared register through any other port window changes nothing.
// - revision, scratch, frame length, pause quanta, phy addresses, ipg are shared.
// - offsets 0x18 to 0x38 route to the statistics counters.
// - offset 0x3A is transmit command, 0x3B is receive command.
// - with extended counters built, 0x3C to 0x3E return counter upper halves.
// - every access takes a fixed three cycles; host must tolerate wait states.
`timescale 1ns/1ps
`default_nettype none
`include "mcm_csr_map.svh"
module mcm_csr_decoder
  import mcm_pkg::*;
#(
  parameter int               NPORTS    = 2,            // ports in the build
  parameter bit               EXT_STATS = 1'b1,         // extended counter option
  parameter mcm_pkg::mcm_word_t REV_VALUE = 32'h0000_0A5A // arbitrary revision value
)
(
  input  wire logic                     clk,              // csr clock
  input  wire logic                     reset_n,          // synchronous reset
  input  wire logic [((NPORTS > 1) ? $clog2(NPORTS) : 1)+7:0] address, // window and offset
  input  wire logic                     read,             // read request
  input  wire logic                     write,            // write request
  input  wire mcm_pkg::mcm_word_t       writedata,        // write data
  output mcm_pkg::mcm_word_t            readdata,         // read data, valid at done
  output logic                          waitrequest,      // stall while access runs
  output mcm_pkg::mcm_req_s             grp_req,          // access to an outside group
  output logic                          base_rd,          // base group read strobe
  output logic                          base_wr,          // base group write strobe
  input  wire mcm_pkg::mcm_word_t       base_rdata,       // base group read data
  output logic                          stat_rd,          // counter read strobe
  input  wire mcm_pkg::mcm_word_t       stat_rdata,       // counter read data
  output logic                          ext_rd,           // upper counter read strobe
  input  wire mcm_pkg::mcm_word_t       ext_rdata,        // upper counter read data
  output logic [NPORTS-1:0][31:0]       transmit_command, // per-port transmit command
  output logic [NPORTS-1:0][31:0]       receive_command   // per-port receive command
);
  import mcm_pkg::*;

  localparam int PW = (NPORTS > 1) ? $clog2(NPORTS) : 1;

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic logic [3:0] shared_slot(input logic [7:0] off);
    logic [3:0] r;
    r = 4'h0;
    case (off)
      `MCM_SCRATCH:      r = {1'b1, `MCM_SLOT_SCRATCH};
      `MCM_FRAME_LEN:    r = {1'b1, `MCM_SLOT_FRAME};
      `MCM_PAUSE_QUANTA: r = {1'b1, `MCM_SLOT_PAUSE};
      `MCM_PHY_ADDR_1ST: r = {1'b1, `MCM_SLOT_PHY1};
      `MCM_PHY_ADDR_2ND: r = {1'b1, `MCM_SLOT_PHY2};
      `MCM_TX_IPG_LEN:   r = {1'b1, `MCM_SLOT_IPG};
      default:           r = 4'h0;
    endcase
    return r;
  endfunction : shared_slot

  wire logic [PW-1:0] port_idx  = address[PW+7:`MCM_WIN_BITS];
  wire logic [7:0]    off       = address[7:0];
  wire logic          port_ok   = 32'(port_idx) < NPORTS;
  wire logic          first     = port_idx == '0;
  wire logic          access    = read | write;
  wire logic [3:0]    slot      = shared_slot(off);
  wire logic          rev_hit   = port_ok && off == `MCM_REVISION;
  wire logic          sh_hit    = port_ok && slot[3];
  wire logic          base_hit  = port_ok && off <= `MCM_BASE_HI && !rev_hit && !sh_hit;
  wire logic          stat_hit  = port_ok && off >= `MCM_STAT_LO && off <= `MCM_STAT_HI;
  wire logic          txc_hit   = port_ok && off == `MCM_TX_CMD;
  wire logic          rxc_hit   = port_ok && off == `MCM_RX_CMD;
  wire logic          ext_hit   = EXT_STATS && port_ok
                                  && off >= `MCM_EXT_LO && off <= `MCM_EXT_HI;
  wire logic          mapped    = rev_hit | sh_hit | base_hit | stat_hit
                                  | txc_hit | rxc_hit | ext_hit;

  // ****************************************************************
  // access sequencing
  // ****************************************************************
  // fixed three-cycle access: issue, capture, done; the host sees the
  // wait states through waitrequest and must not assume a count
  mcm_phase_e ph_q;
  mcm_phase_e ph_d;
  mcm_word_t  rdata_q;
  mcm_word_t  rdata_d;
  mcm_word_t  sh_rdata;

  wire logic issue = access && ph_q == MCM_PH_ISSUE_S;
  wire logic done  = access && ph_q == MCM_PH_DONE_S;

  always_comb
  begin
    case (ph_q)
      MCM_PH_ISSUE_S:   ph_d = access ? MCM_PH_CAPTURE_S : MCM_PH_ISSUE_S;
      MCM_PH_CAPTURE_S: ph_d = MCM_PH_DONE_S;
      MCM_PH_DONE_S:    ph_d = MCM_PH_ISSUE_S;
      default:          ph_d = MCM_PH_ISSUE_S;
    endcase
  end

  assign waitrequest = access && !done;

  assign grp_req.port   = 8'(port_idx);
  assign grp_req.offset = off;
  assign grp_req.wdata  = writedata;
  assign base_rd        = issue && read && base_hit;
  assign base_wr        = done && write && base_hit;
  assign stat_rd        = issue && read && stat_hit;
  assign ext_rd         = issue && read && ext_hit;

  // unmapped offsets, 0x39, the reserved word and windows beyond the
  // last port fall to zero
  always_comb
  begin
    rdata_d = `MCM_ZERO_WORD;
    if (rev_hit)
      rdata_d = REV_VALUE;
    else if (sh_hit)
      rdata_d = sh_rdata;
    else if (base_hit)
      rdata_d = base_rdata;
    else if (stat_hit)
      rdata_d = stat_rdata;
    else if (txc_hit)
      rdata_d = transmit_command[port_idx];
    else if (rxc_hit)
      rdata_d = receive_command[port_idx];
    else if (ext_hit)
      rdata_d = ext_rdata;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ph_q    <= MCM_PH_ISSUE_S;
      rdata_q <= `MCM_ZERO_WORD;
    end
    else
    begin
      ph_q <= ph_d;
      if (ph_q == MCM_PH_CAPTURE_S)
        rdata_q <= read ? rdata_d : `MCM_ZERO_WORD;
    end
  end

  assign readdata = rdata_q;

  // ****************************************************************
  // shared storage
  // ****************************************************************
  // reads of a shared register through any port window see the first window's copy
  wire logic sh_wr = done && write && sh_hit && first;

  mcm_shared_store u_store (
    .clk     (clk),
    .reset_n (reset_n),
    .wr_en   (sh_wr),
    .wr_slot (slot[2:0]),
    .wr_data (writedata),
    .rd_slot (slot[2:0]),
    .rd_data (sh_rdata)
  );

  // ****************************************************************
  // per-port command registers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        transmit_command[p] <= `MCM_CMD_RESET;
        receive_command[p]  <= `MCM_CMD_RESET;
      end
    end
    else if (done && write)
    begin
      if (txc_hit)
        transmit_command[port_idx] <= writedata;
      if (rxc_hit)
        receive_command[port_idx] <= writedata;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  txc_write_a: assert property (done && write && txc_hit |=>
    transmit_command[$past(port_idx)] == $past(writedata))
    else $error("transmit command not written");
  rxc_read_a: assert property (ph_q == MCM_PH_CAPTURE_S && read && rxc_hit |=>
    readdata == $past(receive_command[port_idx]))
    else $error("receive command read wrong");
  // a write through a later window must leave the stored copy as it was
  shared_guard_a: assert property (done && write && sh_hit && !first |=>
    u_store.mem_q[$past(slot[2:0])] == $past(u_store.mem_q[slot[2:0]]))
    else $error("shared write outside first window");
  shared_read_a: assert property (ph_q == MCM_PH_CAPTURE_S && read && sh_hit |=>
    readdata == $past(sh_rdata))
    else $error("shared read wrong");
  unmapped_zero_a: assert property (ph_q == MCM_PH_CAPTURE_S && !mapped |=>
    readdata == `MCM_ZERO_WORD)
    else $error("unmapped read not zero");
  wait_bound_a: assert property (issue |->
    waitrequest ##1 waitrequest ##1 !waitrequest)
    else $error("access not done in three cycles");
  stat_route_a: assert property (stat_rd |->
    off >= `MCM_STAT_LO && off <= `MCM_STAT_HI && !base_rd && !ext_rd)
    else $error("counter strobe outside range");
  ext_gate_a: assert property (ext_rd |-> EXT_STATS && off >= `MCM_EXT_LO)
    else $error("upper counter strobe without option");
  window_port_a: assert property (access |->
    grp_req.port == 8'(address >> `MCM_WIN_BITS))
    else $error("port window index wrong");

endmodule : mcm_csr_decoder
`default_nettype wire

/* hdl/mcm_csr_map.svh */
// offsets, field widths and reset values of the mac csr address map
// assumes: included by the design files by bare name
`ifndef MCM_CSR_MAP_SVH
`define MCM_CSR_MAP_SVH

// dword offsets inside one port window
`define MCM_WIN_BITS      8
`define MCM_BASE_LO       8'h00
`define MCM_BASE_HI       8'h17
`define MCM_STAT_LO       8'h18
`define MCM_STAT_HI       8'h38
`define MCM_TX_CMD        8'h3A
`define MCM_RX_CMD        8'h3B
`define MCM_EXT_LO        8'h3C
`define MCM_EXT_HI        8'h3E
`define MCM_RSVD_WORD     8'h3F

// shared registers of the base group
`define MCM_REVISION      8'h00
`define MCM_SCRATCH       8'h01
`define MCM_FRAME_LEN     8'h05
`define MCM_PAUSE_QUANTA  8'h06
`define MCM_PHY_ADDR_1ST  8'h0F
`define MCM_PHY_ADDR_2ND  8'h10
`define MCM_TX_IPG_LEN    8'h17

// shared store slots
`define MCM_SLOT_SCRATCH  3'h0
`define MCM_SLOT_FRAME    3'h1
`define MCM_SLOT_PAUSE    3'h2
`define MCM_SLOT_PHY1     3'h3
`define MCM_SLOT_PHY2     3'h4
`define MCM_SLOT_IPG      3'h5

// reset values and access phases
`define MCM_CMD_RESET     32'h0000_0000
`define MCM_ZERO_WORD     32'h0000_0000
`define MCM_PH_ISSUE      2'h0
`define MCM_PH_CAPTURE    2'h1
`define MCM_PH_DONE       2'h2

`endif

/* hdl/mcm_pkg.sv */
// types shared by the mac csr address map modules
// assumes: mcm_csr_map.svh on the include path
package mcm_pkg;

  typedef logic [31:0] mcm_word_t;

  // one access forwarded to an outside register group
  typedef struct packed {
    logic [7:0] port;    // port window index
    logic [7:0] offset;  // dword offset inside the window
    mcm_word_t  wdata;   // write data
  } mcm_req_s;

  typedef enum logic [1:0] {
    MCM_PH_ISSUE_S   = 2'b00,
    MCM_PH_CAPTURE_S = 2'b01,
    MCM_PH_DONE_S    = 2'b10
  } mcm_phase_e;

endpackage : mcm_pkg

/* hdl/mcm_shared_store.sv */
// storage of the registers common to all ports; registered read data
// assumes: one clock, synchronous active-low reset, one write port
`timescale 1ns/1ps
`default_nettype none
`include "mcm_csr_map.svh"
module mcm_shared_store
  import mcm_pkg::*;
(
  input  wire logic          clk,       // csr clock
  input  wire logic          reset_n,   // synchronous reset, active low
  input  wire logic          wr_en,     // write strobe
  input  wire logic [2:0]    wr_slot,   // write slot
  input  wire mcm_pkg::mcm_word_t wr_data, // write data
  input  wire logic [2:0]    rd_slot,   // read slot
  output mcm_pkg::mcm_word_t rd_data    // read data, one cycle after rd_slot
);
  import mcm_pkg::*;

  mcm_word_t mem_q [8];
  mcm_word_t rd_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 8; i++)
        mem_q[i] <= `MCM_ZERO_WORD;
      rd_q <= `MCM_ZERO_WORD;
    end
    else
    begin
      if (wr_en)
        mem_q[wr_slot] <= wr_data;
      rd_q <= mem_q[rd_slot];
    end
  end

  assign rd_data = rd_q;

endmodule : mcm_shared_store
`default_nettype wire

/* verification/mcm_host_model.sv */
// host model: single-word master on the csr decoder's request port
// assumes: one clock; the device raises waitrequest until it completes
`timescale 1ns/1ps
`default_nettype none
module mcm_host_model
  import mcm_pkg::*;
#(
  parameter int AW = 10 // address width
)
(
  input  wire logic               clk,         // csr clock
  input  wire logic               waitrequest, // stall from the device
  input  wire mcm_pkg::mcm_word_t readdata,    // read data
  output logic [AW-1:0]           address,     // port window and offset
  output logic                    read,        // read request
  output logic                    write,       // write request
  output mcm_pkg::mcm_word_t      writedata    // write data
);
  initial
  begin
    address   = '0;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0000_0000;
  end

  // request held until waitrequest is seen low, answer taken at that edge
  task automatic xfer(input logic wr, input logic [AW-1:0] a, input mcm_word_t d,
                      output mcm_word_t q, output bit ok);
    int n;
    begin
      @(posedge clk);
      address   <= a;
      writedata <= d;
      read      <= !wr;
      write     <= wr;
      ok = 1'b0;
      for (n = 0; n < 16 && !ok; n++)
      begin
        #1;
        if (waitrequest === 1'b0) ok = 1'b1;
        else @(posedge clk);
      end
      @(posedge clk);
      q = readdata;
      read      <= 1'b0;
      write     <= 1'b0;
      // released lines must not keep the last value
      address   <= ~a;
      writedata <= ~d;
    end
  endtask : xfer
endmodule : mcm_host_model
`default_nettype wire

/* verification/test_mac_csr_address_map.sv */
// bench for the csr decoder: host model, group responders, reference map
// assumes: three ports, extended counters built, groups answer in one cycle
`timescale 1ns/1ps
`default_nettype none
module test_mac_csr_address_map;
  import mcm_pkg::*;
  localparam int        NP  = 3;
  localparam int        AW  = 10;
  localparam mcm_word_t REV = 32'h0000_0C3D; // arbitrary revision value
  logic                 clk = 1'b0, reset_n = 1'b0, read, write, waitrequest;
  logic                 base_rd, base_wr, stat_rd, ext_rd;
  logic [AW-1:0]        address;
  mcm_word_t            writedata, readdata;
  mcm_word_t            base_rdata = '0, stat_rdata = '0, ext_rdata = '0;
  mcm_req_s             grp_req;
  logic [NP-1:0][31:0]  tx_cmd, rx_cmd;
  int                   error_cnt = 0, total_checks = 0, cyc = 0, seed = 90;
  int                   n_brd = 0, n_bwr = 0, n_srd = 0, n_erd = 0;
  logic [7:0]           bwr_off;
  mcm_word_t            bwr_dat, rd_noext;
  mcm_word_t            tx_m [NP], rx_m [NP], shr_m [int];
  logic [7:0]           offs [19] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h0F, 8'h10,
    8'h17, 8'h18, 8'h2A, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3E, 8'h3F, 8'h40, 8'hFF};

  always #4 clk = ~clk;

  mcm_host_model #(.AW(AW)) i_host (.clk(clk), .waitrequest(waitrequest),
    .readdata(readdata), .address(address), .read(read), .write(write),
    .writedata(writedata));

  mcm_csr_decoder #(.NPORTS(NP), .EXT_STATS(1'b1), .REV_VALUE(REV)) i_dut (
    .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .grp_req(grp_req), .base_rd(base_rd), .base_wr(base_wr), .base_rdata(base_rdata),
    .stat_rd(stat_rd), .stat_rdata(stat_rdata), .ext_rd(ext_rd), .ext_rdata(ext_rdata),
    .transmit_command(tx_cmd), .receive_command(rx_cmd));

  // second build without the extended counters, fed the same requests
  mcm_csr_decoder #(.NPORTS(NP), .EXT_STATS(1'b0), .REV_VALUE(REV)) i_dut_noext (
    .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(rd_noext), .waitrequest(), .grp_req(),
    .base_rd(), .base_wr(), .base_rdata(base_rdata), .stat_rd(), .stat_rdata(stat_rdata),
    .ext_rd(), .ext_rdata(ext_rdata), .transmit_command(), .receive_command());

  // outside groups: data tagged with group, port and offset, one cycle late
  always @(posedge clk)
  begin
    base_rdata <= {8'hB0, grp_req.port, grp_req.offset, 8'h5A};
    stat_rdata <= {8'hC0, grp_req.port, grp_req.offset, 8'h5A};
    ext_rdata  <= {8'hE0, grp_req.port, grp_req.offset, 8'h5A};
    if (base_rd) n_brd <= n_brd + 1;
    if (base_wr) n_bwr <= n_bwr + 1;
    if (stat_rd) n_srd <= n_srd + 1;
    if (ext_rd) n_erd <= n_erd + 1;
    if (base_wr)
    begin
      bwr_off <= grp_req.offset;
      bwr_dat <= grp_req.wdata;
    end
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  function automatic bit shared(int o);
    return o inside {8'h01, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h17};
  endfunction : shared

  function automatic mcm_word_t expect_rd(int p, int o);
    if (p >= NP) return 32'h0000_0000;
    if (o == 8'h00) return REV;
    if (shared(o)) return shr_m.exists(o) ? shr_m[o] : 32'h0000_0000;
    if (o <= 8'h17) return {8'hB0, 8'(p), 8'(o), 8'h5A};
    if (o <= 8'h38) return {8'hC0, 8'(p), 8'(o), 8'h5A};
    if (o == 8'h3A) return tx_m[p];
    if (o == 8'h3B) return rx_m[p];
    if (o >= 8'h3C && o <= 8'h3E) return {8'hE0, 8'(p), 8'(o), 8'h5A};
    return 32'h0000_0000;
  endfunction : expect_rd

  task automatic cmp(string what, mcm_word_t exp, mcm_word_t got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic access(logic wr, int p, int o, mcm_word_t d, output mcm_word_t q);
    bit ok;
    bit bg;
    bit st;
    bit ex;
    int b0, w0, s0, e0;
    bg = p < NP && o != 8'h00 && o <= 8'h17 && !shared(o);
    st = p < NP && o >= 8'h18 && o <= 8'h38;
    ex = p < NP && o >= 8'h3C && o <= 8'h3E;
    b0 = n_brd;
    w0 = n_bwr;
    s0 = n_srd;
    e0 = n_erd;
    i_host.xfer(wr, {2'(p), 8'(o)}, d, q, ok);
    #1;
    cmp("completion", 32'h1, {31'h0, ok});
    cmp("base_rd count", 32'(bg && !wr), 32'(n_brd - b0));
    cmp("base_wr count", 32'(bg && wr), 32'(n_bwr - w0));
    cmp("stat_rd count", 32'(st && !wr), 32'(n_srd - s0));
    cmp("ext_rd count", 32'(ex && !wr), 32'(n_erd - e0));
    if (bg && wr)
    begin
      cmp("base write offset", 32'(o), 32'(bwr_off));
      cmp("base write data", d, bwr_dat);
    end
  endtask : access

  task automatic chk(int p, int o);
    mcm_word_t q;
    mcm_word_t e;
    access(1'b0, p, o, 32'h0000_0000, q);
    e = expect_rd(p, o);
    cmp($sformatf("read %0d:%h", p, o), e, q);
    if (o >= 8'h3C && o <= 8'h3E) e = 32'h0000_0000;
    cmp("read without ext", e, rd_noext);
  endtask : chk

  task automatic wr(int p, int o, mcm_word_t d);
    mcm_word_t q;
    int k;
    access(1'b1, p, o, d, q);
    if (p < NP && o == 8'h3A) tx_m[p] = d;
    else if (p < NP && o == 8'h3B) rx_m[p] = d;
    else if (p == 0 && shared(o)) shr_m[o] = d;
    #1;
    for (k = 0; k < NP; k++)
    begin
      cmp("transmit_command", tx_m[k], tx_cmd[k]);
      cmp("receive_command", rx_m[k], rx_cmd[k]);
    end
  endtask : wr

  task automatic conclude();
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  initial
  begin
    int p, o, k;
    mcm_word_t d;
    for (k = 0; k < NP; k++)
    begin
      tx_m[k] = 32'h0000_0000;
      rx_m[k] = 32'h0000_0000;
    end
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    // every window, including one past the last port, before any write
    for (p = 0; p < 4; p++)
      for (k = 0; k < 19; k++) chk(p, offs[k]);
    wr(0, 8'h02, 32'h1234_5678);
    wr(0, 8'h3A, 32'h0000_0003);
    for (k = 0; k < 300; k++)
    begin
      p = $unsigned($random(seed)) % 4;
      o = offs[$unsigned($random(seed)) % 19];
      d = $random(seed);
      if (o == 8'h3F) d = 32'h0000_0000;
      wr(p, o, d);
      chk($unsigned($random(seed)) % 4, offs[$unsigned($random(seed)) % 19]);
    end
    conclude();
  end
endmodule : test_mac_csr_address_map
`default_nettype wire
